// *** src/drive_serial_control_status.v ***
// serial control and status word bank with link and keypad watchdogs
`include "drive_serial_control_status_defines.vh"

// What this block does
// - fault watchdog with serial direction/speed control: no telegram in timeout gives 42, coast
// - warning watchdog: no telegram in timeout gives code 58, drive keeps running
// - keypad link rate selectable 9600 or 19200, default 19200
// - keypad needed and silent for 2.0-60.0 s gives fault 40
// - control word one bits 0-3: serial command, serial reference, forward, reverse
// - control word one bit 4 selects second external reference
// - control word one bits 5-7 form preset speed, bit 5 lowest
// - control word one bits 8,9 command alternate ramps one and two
// - bit 10 selects remote, bit 11 selects terminal strip path
// - bit 12 starts injection braking
// - bit 13 freewheel stop, bit 15 resets inverter, bit 14 does nothing
// - sequencer mode ignores control word one bits 10 and 11
// - control word two bit 0 enables sequencer or PID; bits 1,2 pause, reset
// - control word two bits 6-12 drive relays one, two, digital outputs, relays A, B
// - bits 13-15 signal network timeout fault, warning, forced fault; 13,14 masked in sequencer
// - two external references, 0.00 Hz up to max frequency, reset 0.00 Hz
// - status one bits 0,1 report serial command and frequency control active
// - status one bits 2-7 report run direction, reference B, ramp and speed state
// - status one bits 8-15 report ramps, remote, keypad, braking, jog, zero, locked fault
// - sequencer mode forces status one bit 10 to zero
// - status three bits 0-7 report ready, enable, local, warning, limits, follower, wire
// - status three bits 8-10 sequencer state, 13-15 undervoltage, overtemperature, fault
// - link watchdog only active in warning or fault mode
module drive_serial_control_status #(
  parameter SEC_CYCLES   = `SECOND_CYCLES,
  parameter TENTH_CYCLES = `TENTH_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // parameter access from the protocol engine
  input  wire        parWrEn,
  input  wire        parRdEn,
  input  wire [15:0] parAddr,
  input  wire [15:0] parWrData,
  output reg  [15:0] parRdData_q,
  output reg         parRdValid_q,
  output reg         parAddrErr_q,
  // link events
  input  wire        telegramValid,
  input  wire        keypadRespond,
  // configuration
  input  wire [1:0]  netTimeoutMode,
  input  wire [5:0]  netTimeoutSec,
  input  wire        keypadRateLow,
  input  wire [9:0]  keypadWatchdogTime,
  input  wire        keypadCtrlNeedsEnhanced,
  input  wire        sequencerMode,
  input  wire        serialOptionAvailable,
  input  wire [15:0] maxFreq,
  // drive state for status words
  input  wire        runFwd,
  input  wire        runRev,
  input  wire        accelerating,
  input  wire        decelerating,
  input  wire        atSpeed,
  input  wire        keypadDirection,
  input  wire        injBrakeActive,
  input  wire        jogging,
  input  wire        runZeroSpeed,
  input  wire        lockedFault,
  input  wire        readyToRun,
  input  wire        enableInput,
  input  wire        forcedLocal,
  input  wire        warningActive,
  input  wire        currentLimit,
  input  wire        torqueLimit,
  input  wire        followerLoss,
  input  wire        brokenWire,
  input  wire        seqRunning,
  input  wire        seqPaused,
  input  wire        underVoltage,
  input  wire        overTemp,
  input  wire        faultNotLocked,
  // drive commands
  output reg         serialCommandActive_q,
  output reg         serialFrequencyActive_q,
  output reg         fwdCmd_q,
  output reg         revCmd_q,
  output reg  [2:0]  presetSel_q,
  output reg         altRampOne_q,
  output reg         altRampTwo_q,
  output reg         remoteCmd_q,
  output reg         terminalPath_q,
  output reg         injBrakeCmd_q,
  output reg         coastStop_q,
  output reg         resetInverter_q,
  output reg  [15:0] activeRef_q,
  output reg         seqEnable_q,
  output reg         pidEnable_q,
  output reg         seqPause_q,
  output reg         seqReset_q,
  output reg         relayOutOne_q,
  output reg         relayOutTwo_q,
  output reg         digitalOutOne_q,
  output reg         digitalOutTwo_q,
  output reg         digitalOutThree_q,
  output reg         relayOutA_q,
  output reg         relayOutB_q,
  output reg         netFaultReq_q,
  output reg         netWarnReq_q,
  output reg         netForcedFault_q,
  // watchdog results and keypad baud divider
  output reg         linkFault_q,
  output reg         linkWarn_q,
  output reg         keypadFault_q,
  output reg  [7:0]  faultCode_q,
  output reg  [15:0] keypadBaudDiv_q
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  reg  [15:0] ctrlPrimary_q;
  reg  [15:0] ctrlSecondary_q;
  reg  [15:0] extFreqRefA_q;
  reg  [15:0] extFreqRefB_q;
  reg  [31:0] secDiv_q;
  reg  [31:0] tenthDiv_q;
  reg  [5:0]  linkSecs_q;
  reg  [9:0]  keypadTenths_q;

  wire [15:0] statusPrimary;
  wire [15:0] statusTertiary;
  wire        secTick;
  wire        tenthTick;
  wire        cmdPath;
  wire        wdActive;
  wire        linkExpired;
  wire        keypadExpired;
  wire        invReset;

  localparam [31:0] BAUD_HI_W = `BAUD_DIV_HI;
  localparam [31:0] BAUD_LO_W = `BAUD_DIV_LO;

  // clamp to the configured maximum frequency
  function [15:0] clampFreq;
    input [15:0] value;
    input [15:0] limit;
    begin
      clampFreq = (value > limit) ? limit : value;
    end
  endfunction

  // true when a write hits the given address
  function wrHit;
    input        en;
    input [15:0] addr;
    input [15:0] ofs;
    begin
      wrHit = en && (addr == ofs);
    end
  endfunction

  assign cmdPath  = ctrlPrimary_q[`CW1_SERIAL_CMD];
  assign invReset = wrHit(parWrEn, parAddr, `OFS_CONTROL_WORD_PRIMARY)
                    && parWrData[`CW1_RESET_INV];

  ////////////////////////////////////////////////////////////////////////////
  // parameter writes

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlPrimary_q   <= `RST_CONTROL_WORD;
      ctrlSecondary_q <= `RST_CONTROL_WORD;
      extFreqRefA_q   <= `RST_FREQ_REF;
      extFreqRefB_q   <= `RST_FREQ_REF;
    end else begin
      if (wrHit(parWrEn, parAddr, `OFS_CONTROL_WORD_PRIMARY)) begin
        ctrlPrimary_q <= parWrData;
      end
      if (wrHit(parWrEn, parAddr, `OFS_CONTROL_WORD_SECONDARY)) begin
        ctrlSecondary_q <= parWrData;
      end
      if (wrHit(parWrEn, parAddr, `OFS_EXT_FREQ_REF_A)) begin
        extFreqRefA_q <= clampFreq(parWrData, maxFreq);
      end
      if (wrHit(parWrEn, parAddr, `OFS_EXT_FREQ_REF_B)) begin
        extFreqRefB_q <= clampFreq(parWrData, maxFreq);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status words

  assign statusPrimary = {
    lockedFault | linkFault_q | keypadFault_q,
    runZeroSpeed,
    jogging,
    injBrakeActive,
    keypadDirection,
    remoteCmd_q & ~sequencerMode,
    altRampTwo_q,
    altRampOne_q,
    atSpeed,
    decelerating,
    accelerating,
    serialFrequencyActive_q & ctrlPrimary_q[`CW1_USE_REF_B],
    runRev,
    runFwd,
    serialFrequencyActive_q & serialOptionAvailable,
    serialCommandActive_q & serialOptionAvailable
  };

  assign statusTertiary = {
    faultNotLocked,
    overTemp,
    underVoltage,
    2'b00,
    seqPaused,
    seqRunning,
    seqEnable_q,
    brokenWire,
    followerLoss,
    torqueLimit,
    currentLimit,
    warningActive | linkWarn_q,
    forcedLocal,
    enableInput,
    readyToRun
  };

  // read answer one cycle after the strobe; writes to read-only words flag an error
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parRdData_q  <= 16'h0000;
      parRdValid_q <= 1'b0;
      parAddrErr_q <= 1'b0;
    end else begin
      parRdValid_q <= parRdEn;
      parAddrErr_q <= 1'b0;
      if (parRdEn) begin
        case (parAddr)
          `OFS_STATUS_WORD_PRIMARY:    parRdData_q <= statusPrimary;
          `OFS_STATUS_WORD_TERTIARY:   parRdData_q <= statusTertiary;
          `OFS_CONTROL_WORD_PRIMARY:   parRdData_q <= ctrlPrimary_q;
          `OFS_CONTROL_WORD_SECONDARY: parRdData_q <= ctrlSecondary_q;
          `OFS_EXT_FREQ_REF_A:         parRdData_q <= extFreqRefA_q;
          `OFS_EXT_FREQ_REF_B:         parRdData_q <= extFreqRefB_q;
          default: begin
            parRdData_q  <= 16'h0000;
            parAddrErr_q <= 1'b1;
          end
        endcase
      end
      if (parWrEn && (parAddr != `OFS_CONTROL_WORD_PRIMARY)
          && (parAddr != `OFS_CONTROL_WORD_SECONDARY)
          && (parAddr != `OFS_EXT_FREQ_REF_A)
          && (parAddr != `OFS_EXT_FREQ_REF_B)) begin
        parAddrErr_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base

  assign secTick   = (secDiv_q == SEC_CYCLES - 1);
  assign tenthTick = (tenthDiv_q == TENTH_CYCLES - 1);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secDiv_q   <= 32'h0;
      tenthDiv_q <= 32'h0;
    end else begin
      secDiv_q   <= secTick ? 32'h0 : secDiv_q + 32'h1;
      tenthDiv_q <= tenthTick ? 32'h0 : tenthDiv_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdogs

  // armed only in warning or fault mode
  assign wdActive = (netTimeoutMode == `WD_MODE_WARN) || (netTimeoutMode == `WD_MODE_FAULT);
  // a zero timeout setting behaves as the one second minimum
  assign linkExpired = wdActive && secTick && !telegramValid
                       && (linkSecs_q + 6'h1 >= netTimeoutSec);
  assign keypadExpired = keypadCtrlNeedsEnhanced && tenthTick && !keypadRespond
                         && (keypadTenths_q + 10'h1 >= keypadWatchdogTime);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkSecs_q     <= 6'h0;
      keypadTenths_q <= 10'h0;
      linkFault_q    <= 1'b0;
      linkWarn_q     <= 1'b0;
      keypadFault_q  <= 1'b0;
    end else begin
      if (telegramValid || !wdActive) begin
        linkSecs_q <= 6'h0;
      end else if (secTick && !linkExpired) begin
        linkSecs_q <= linkSecs_q + 6'h1;
      end else if (linkExpired) begin
        linkSecs_q <= 6'h0;
      end
      if (keypadRespond || !keypadCtrlNeedsEnhanced || keypadExpired) begin
        keypadTenths_q <= 10'h0;
      end else if (tenthTick) begin
        keypadTenths_q <= keypadTenths_q + 10'h1;
      end
      // latched until inverter reset; a new expiry wins over the reset
      if (linkExpired && (netTimeoutMode == `WD_MODE_FAULT)
          && (ctrlPrimary_q[`CW1_SERIAL_CMD] || ctrlPrimary_q[`CW1_SERIAL_REF])) begin
        linkFault_q <= 1'b1;
      end else if (invReset) begin
        linkFault_q <= 1'b0;
      end
      // warning drops on the next good telegram
      if (linkExpired && (netTimeoutMode == `WD_MODE_WARN)) begin
        linkWarn_q <= 1'b1;
      end else if (telegramValid || !wdActive) begin
        linkWarn_q <= 1'b0;
      end
      // keypad loss latched until inverter reset
      if (keypadExpired) begin
        keypadFault_q <= 1'b1;
      end else if (invReset) begin
        keypadFault_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serialCommandActive_q   <= 1'b0;
      serialFrequencyActive_q <= 1'b0;
      fwdCmd_q          <= 1'b0;
      revCmd_q          <= 1'b0;
      presetSel_q       <= 3'h0;
      altRampOne_q      <= 1'b0;
      altRampTwo_q      <= 1'b0;
      remoteCmd_q       <= 1'b0;
      terminalPath_q    <= 1'b0;
      injBrakeCmd_q     <= 1'b0;
      coastStop_q       <= 1'b0;
      resetInverter_q   <= 1'b0;
      activeRef_q       <= `RST_FREQ_REF;
      seqEnable_q       <= 1'b0;
      pidEnable_q       <= 1'b0;
      seqPause_q        <= 1'b0;
      seqReset_q        <= 1'b0;
      relayOutOne_q     <= 1'b0;
      relayOutTwo_q     <= 1'b0;
      digitalOutOne_q   <= 1'b0;
      digitalOutTwo_q   <= 1'b0;
      digitalOutThree_q <= 1'b0;
      relayOutA_q       <= 1'b0;
      relayOutB_q       <= 1'b0;
      netFaultReq_q     <= 1'b0;
      netWarnReq_q      <= 1'b0;
      netForcedFault_q  <= 1'b0;
      faultCode_q       <= `CODE_NONE;
      keypadBaudDiv_q   <= BAUD_HI_W[15:0];
    end else begin
      serialCommandActive_q   <= cmdPath;
      serialFrequencyActive_q <= ctrlPrimary_q[`CW1_SERIAL_REF];
      fwdCmd_q <= cmdPath & ctrlPrimary_q[`CW1_FWD];
      revCmd_q <= cmdPath & ctrlPrimary_q[`CW1_REV];
      presetSel_q <= cmdPath ? ctrlPrimary_q[`CW1_PRESET_MSB:`CW1_PRESET_LSB] : 3'h0;
      altRampOne_q <= cmdPath & ctrlPrimary_q[`CW1_ALT_RAMP1];
      altRampTwo_q <= cmdPath & ctrlPrimary_q[`CW1_ALT_RAMP2];
      remoteCmd_q    <= ~sequencerMode & ctrlPrimary_q[`CW1_REMOTE];
      terminalPath_q <= ~sequencerMode & ctrlPrimary_q[`CW1_TERMINAL];
      injBrakeCmd_q <= cmdPath & ctrlPrimary_q[`CW1_INJ_BRAKE];
      // freewheel, reset pulse; bit 14 unused
      coastStop_q     <= (cmdPath & ctrlPrimary_q[`CW1_FREEWHEEL]) | linkFault_q;
      resetInverter_q <= invReset;
      if (ctrlPrimary_q[`CW1_SERIAL_REF]) begin
        activeRef_q <= ctrlPrimary_q[`CW1_USE_REF_B] ? extFreqRefB_q : extFreqRefA_q;
      end else begin
        activeRef_q <= `RST_FREQ_REF;
      end
      seqEnable_q <= sequencerMode & ctrlSecondary_q[`CW2_ENABLE];
      pidEnable_q <= ~sequencerMode & ctrlSecondary_q[`CW2_ENABLE];
      seqPause_q  <= sequencerMode & ctrlSecondary_q[`CW2_SEQ_PAUSE];
      seqReset_q  <= sequencerMode & ctrlSecondary_q[`CW2_SEQ_RESET];
      relayOutOne_q     <= ctrlSecondary_q[`CW2_RELAY_ONE];
      relayOutTwo_q     <= ctrlSecondary_q[`CW2_RELAY_TWO];
      digitalOutOne_q   <= ctrlSecondary_q[`CW2_DOUT_ONE];
      digitalOutTwo_q   <= ctrlSecondary_q[`CW2_DOUT_TWO];
      digitalOutThree_q <= ctrlSecondary_q[`CW2_DOUT_THREE];
      relayOutA_q       <= ctrlSecondary_q[`CW2_RELAY_A];
      relayOutB_q       <= ctrlSecondary_q[`CW2_RELAY_B];
      // network requests, timeout bits masked in sequencer
      netFaultReq_q    <= ~sequencerMode & ctrlSecondary_q[`CW2_NET_FAULT];
      netWarnReq_q     <= ~sequencerMode & ctrlSecondary_q[`CW2_NET_WARN];
      netForcedFault_q <= ctrlSecondary_q[`CW2_NET_FORCED];
      // link fault outranks keypad loss, which outranks the warning
      if (linkFault_q) begin
        faultCode_q <= `CODE_LINK_FAULT;
      end else if (keypadFault_q) begin
        faultCode_q <= `CODE_KEYPAD_LOSS;
      end else if (linkWarn_q) begin
        faultCode_q <= `CODE_LINK_WARN;
      end else begin
        faultCode_q <= `CODE_NONE;
      end
      keypadBaudDiv_q <= keypadRateLow ? BAUD_LO_W[15:0] : BAUD_HI_W[15:0];
    end
  end

endmodule // drive_serial_control_status

// *** src/drive_serial_control_status_defines.vh ***
// register offsets, field positions, reset values and timing for the serial word bank
`ifndef DRIVE_SERIAL_CONTROL_STATUS_DEFINES_VH
`define DRIVE_SERIAL_CONTROL_STATUS_DEFINES_VH

// parameter addresses
`define OFS_STATUS_WORD_PRIMARY   16'h0032
`define OFS_STATUS_WORD_TERTIARY  16'h0034
`define OFS_CONTROL_WORD_PRIMARY  16'h00c9
`define OFS_CONTROL_WORD_SECONDARY 16'h00ca
`define OFS_EXT_FREQ_REF_A        16'h00cb
`define OFS_EXT_FREQ_REF_B        16'h00cd

// reset values
`define RST_CONTROL_WORD          16'h0000
`define RST_FREQ_REF              16'h0000

// first control word fields
`define CW1_SERIAL_CMD   0
`define CW1_SERIAL_REF   1
`define CW1_FWD          2
`define CW1_REV          3
`define CW1_USE_REF_B    4
`define CW1_PRESET_LSB   5
`define CW1_PRESET_MSB   7
`define CW1_ALT_RAMP1    8
`define CW1_ALT_RAMP2    9
`define CW1_REMOTE       10
`define CW1_TERMINAL     11
`define CW1_INJ_BRAKE    12
`define CW1_FREEWHEEL    13
`define CW1_RESET_INV    15

// second control word fields
`define CW2_ENABLE       0
`define CW2_SEQ_PAUSE    1
`define CW2_SEQ_RESET    2
`define CW2_RELAY_ONE    6
`define CW2_RELAY_TWO    7
`define CW2_DOUT_ONE     8
`define CW2_DOUT_TWO     9
`define CW2_DOUT_THREE   10
`define CW2_RELAY_A      11
`define CW2_RELAY_B      12
`define CW2_NET_FAULT    13
`define CW2_NET_WARN     14
`define CW2_NET_FORCED   15

// watchdog modes
`define WD_MODE_OFF      2'h0
`define WD_MODE_WARN     2'h1
`define WD_MODE_FAULT    2'h2

// fault and warning codes
`define CODE_NONE        8'h00
`define CODE_KEYPAD_LOSS 8'h28
`define CODE_LINK_FAULT  8'h2a
`define CODE_LINK_WARN   8'h3a

// timing
`define CLK_HZ           200000000
`define SECOND_CYCLES    (`CLK_HZ)
`define TENTH_CYCLES     (`CLK_HZ / 10)
`define KEYPAD_BAUD_HI   19200
`define KEYPAD_BAUD_LO   9600
`define BAUD_DIV_HI      (`CLK_HZ / `KEYPAD_BAUD_HI)
`define BAUD_DIV_LO      (`CLK_HZ / `KEYPAD_BAUD_LO)

`endif

// *** dv/drive_serial_control_status_checker.sv ***
// port-level assertions for the serial control and status word bank
module drive_serial_control_status_checker #(
  parameter SEC_CYCLES   = 10,
  parameter TENTH_CYCLES = 4
) (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // register port
  input wire        parWrEn,
  input wire [15:0] parAddr,
  input wire [15:0] parWrData,
  // configuration
  input wire [1:0]  netTimeoutMode,
  input wire        keypadRateLow,
  input wire        keypadCtrlNeedsEnhanced,
  input wire        sequencerMode,
  // commands, watchdog results and keypad baud divider
  input wire        serialCommandActive_q,
  input wire        fwdCmd_q,
  input wire        injBrakeCmd_q,
  input wire        remoteCmd_q,
  input wire        terminalPath_q,
  input wire        pidEnable_q,
  input wire        netFaultReq_q,
  input wire        netWarnReq_q,
  input wire        resetInverter_q,
  input wire        coastStop_q,
  input wire        linkFault_q,
  input wire        linkWarn_q,
  input wire        keypadFault_q,
  input wire [7:0]  faultCode_q,
  input wire [15:0] keypadBaudDiv_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire cw1Wr = parWrEn && parAddr == 16'h00c9;
  ////////////////////////////////////////////////////////////////////////////////
  // a second write right behind only reaches the path bit one cycle after this check, yet it is excluded
  a_cw1_serial_path: assert property (cw1Wr ##1 !cw1Wr |=>
    serialCommandActive_q == $past(parWrData[0], 2)) else $error("serial path bit mismatch");
  a_cmd_needs_path: assert property (fwdCmd_q || injBrakeCmd_q |-> serialCommandActive_q)
    else $error("command active without serial path");
  a_seq_no_remote: assert property ($past(sequencerMode) |->
    !remoteCmd_q && !terminalPath_q)
    else $error("remote or terminal active in sequencer mode");
  a_seq_no_net: assert property ($past(sequencerMode) |-> !netFaultReq_q && !netWarnReq_q)
    else $error("network timeout request in sequencer mode");
  a_pid_not_seq: assert property (pidEnable_q |-> !$past(sequencerMode))
    else $error("pid enabled in sequencer mode");
  a_fault_code_42: assert property ($rose(linkFault_q) |-> $past(netTimeoutMode) == 2'h2
    ##1 (faultCode_q == 8'h2a && coastStop_q)) else $error("link fault code or coast wrong");
  a_warn_code_58: assert property ($rose(linkWarn_q) && !linkFault_q && !keypadFault_q |=>
    faultCode_q == 8'h3a) else $error("link warning code wrong");
  a_warn_off_mode: assert property (netTimeoutMode == 2'h0 |=> !linkWarn_q)
    else $error("warning while watchdog off");
  a_baud_select: assert property (1'b1 |=>
    keypadBaudDiv_q == ($past(keypadRateLow) ? 16'h5161 : 16'h28b0)) else $error("baud div");
  a_reset_pulse: assert property (cw1Wr && parWrData[15] |=> resetInverter_q)
    else $error("inverter reset pulse missing");
  a_keypad_code: assert property ($rose(keypadFault_q) |-> $past(keypadCtrlNeedsEnhanced)
    ##1 (faultCode_q == 8'h28 || $past(linkFault_q))) else $error("keypad fault code wrong");
endmodule // drive_serial_control_status_checker

bind drive_serial_control_status drive_serial_control_status_checker #(
  .SEC_CYCLES(SEC_CYCLES), .TENTH_CYCLES(TENTH_CYCLES)) i_drive_serial_control_status_checker (.*);

// *** dv/serial_master_model.sv ***
// remote master model: paced telegram and keypad reply pulses
module serial_master_model (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // pacing, zero keeps that line silent
  input  wire [7:0] telGap,
  input  wire [7:0] kpdGap,
  // link events
  output reg        telegramValid,
  output reg        keypadRespond
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] telCnt_q;
  reg [7:0] kpdCnt_q;
  ////////////////////////////////////////////////////////////////////////////////
  // rising edge, non-blocking: gap inputs move on the falling edge, so no race
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      telCnt_q      <= 8'h00;
      kpdCnt_q      <= 8'h00;
      telegramValid <= 1'b0;
      keypadRespond <= 1'b0;
    end else begin
      telegramValid <= telGap != 8'h00 && telCnt_q == 8'h00;
      keypadRespond <= kpdGap != 8'h00 && kpdCnt_q == 8'h00;
      telCnt_q      <= (telCnt_q == 8'h00) ? telGap : telCnt_q - 8'h01;
      kpdCnt_q      <= (kpdCnt_q == 8'h00) ? kpdGap : kpdCnt_q - 8'h01;
    end
  end
endmodule // serial_master_model

// *** dv/tb_top.sv ***
// self-checking bench for the serial control and status word bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, parWrEn = 1'b0, parRdEn = 1'b0;
  logic [15:0] parAddr = 16'h0000, parWrData = 16'h0000, maxFreq = 16'h1770, d;
  logic [1:0] netTimeoutMode = 2'h0;
  logic [5:0] netTimeoutSec = 6'h02;
  logic [9:0] keypadWatchdogTime = 10'h014;
  logic keypadRateLow = 1'b0, keypadCtrlNeedsEnhanced = 1'b0, sequencerMode = 1'b0;
  logic serialOptionAvailable = 1'b1;
  logic [22:0] drv = 23'h000000;
  logic [7:0] telGap = 8'h00, kpdGap = 8'h00;
  wire runFwd, runRev, accelerating, decelerating, atSpeed, keypadDirection, injBrakeActive,
    jogging, runZeroSpeed, lockedFault, readyToRun, enableInput, forcedLocal, warningActive,
    currentLimit, torqueLimit, followerLoss, brokenWire, seqRunning, seqPaused, underVoltage,
    overTemp, faultNotLocked, telegramValid, keypadRespond;
  wire [15:0] parRdData_q, activeRef_q, keypadBaudDiv_q;
  wire [7:0] faultCode_q;
  wire [2:0] presetSel_q;
  wire parRdValid_q, parAddrErr_q, serialCommandActive_q, serialFrequencyActive_q, fwdCmd_q,
    revCmd_q, altRampOne_q, altRampTwo_q, remoteCmd_q, terminalPath_q, injBrakeCmd_q,
    coastStop_q, resetInverter_q, seqEnable_q, pidEnable_q, seqPause_q, seqReset_q,
    relayOutOne_q, relayOutTwo_q, digitalOutOne_q, digitalOutTwo_q, digitalOutThree_q,
    relayOutA_q, relayOutB_q, netFaultReq_q, netWarnReq_q, netForcedFault_q, linkFault_q,
    linkWarn_q, keypadFault_q;
  wire [12:0] cmdV = {fwdCmd_q, revCmd_q, presetSel_q, altRampOne_q, altRampTwo_q, remoteCmd_q,
    terminalPath_q, injBrakeCmd_q, coastStop_q, serialCommandActive_q, serialFrequencyActive_q};
  wire [13:0] cw2V = {seqEnable_q, pidEnable_q, seqPause_q, seqReset_q, relayOutOne_q,
    relayOutTwo_q, digitalOutOne_q, digitalOutTwo_q, digitalOutThree_q, relayOutA_q,
    relayOutB_q, netFaultReq_q, netWarnReq_q, netForcedFault_q};
  wire [2:0] wdFlags = {linkFault_q, linkWarn_q, keypadFault_q};
  int bad_count = 0;
  int n_checks = 0;
  assign {runFwd, runRev, accelerating, decelerating, atSpeed, keypadDirection, injBrakeActive,
    jogging, runZeroSpeed, lockedFault, readyToRun, enableInput, forcedLocal, warningActive,
    currentLimit, torqueLimit, followerLoss, brokenWire, seqRunning, seqPaused, underVoltage,
    overTemp, faultNotLocked} = drv;
  always #2.5 clk = ~clk;
  // short second and tenth ticks keep the watchdog runs brief
  drive_serial_control_status #(.SEC_CYCLES(10), .TENTH_CYCLES(4))
    i_drive_serial_control_status (.*);
  serial_master_model i_serial_master_model (.clk(clk), .rst_n(rst_n), .telGap(telGap),
    .kpdGap(kpdGap), .telegramValid(telegramValid), .keypadRespond(keypadRespond));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // outputs follow two edges after the strobe, two spare edges added
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(negedge clk);
    parAddr = a;
    parWrData = v;
    parWrEn = 1'b1;
    @(negedge clk);
    parWrEn = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic rc(input logic [15:0] a, input logic [15:0] exp, input logic err);
    int i;
    @(negedge clk);
    parAddr = a;
    parRdEn = 1'b1;
    @(negedge clk);
    parRdEn = 1'b0;
    for (i = 0; i < 4 && parRdValid_q !== 1'b1; i++) @(negedge clk);
    chk(16'h0001, {15'h0000, parRdValid_q});
    if (parRdValid_q !== 1'b1) test_done;
    chk(exp, parRdData_q);
    chk({15'h0000, err}, {15'h0000, parAddrErr_q});
  endtask
  task automatic wt(input logic fl, input int k, input int lim);
    int i;
    for (i = 0; i < lim && wdFlags[2 - k] !== fl; i++) @(negedge clk);
    chk({15'h0000, fl}, {15'h0000, wdFlags[2 - k]});
    if (wdFlags[2 - k] !== fl) test_done;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    foreach (d[i]) if (i < 4) rc(16'h00c9 + 16'(i == 3 ? 4 : i), 16'h0000, 1'b0);
    chk(16'h28b0, keypadBaudDiv_q);
    rc(16'h0040, 16'h0000, 1'b1);
    wr(16'h0032, 16'h0000);
    drv = 23'h7fffff;
    rc(16'h0032, 16'hf8ec, 1'b0);
    rc(16'h0034, 16'he6ff, 1'b0);
    drv = 23'h000000;
    wr(16'h00cb, 16'h1000);
    wr(16'h00cd, 16'hffff);
    rc(16'h00cd, 16'h1770, 1'b0);
    wr(16'h00c9, 16'h0013);
    chk(16'h1770, activeRef_q);
    rc(16'h0032, 16'h0013, 1'b0);
    serialOptionAvailable = 1'b0;
    rc(16'h0032, 16'h0010, 1'b0);
    serialOptionAvailable = 1'b1;
    wr(16'h00c9, 16'h0003);
    chk(16'h1000, activeRef_q);
    wr(16'h00c9, 16'h0021);
    chk(16'h0102, {3'h0, cmdV});
    wr(16'h00c9, 16'h0081);
    chk(16'h0402, {3'h0, cmdV});
    wr(16'h00c9, 16'h7fee);
    chk(16'h0031, {3'h0, cmdV});
    wr(16'h00c9, 16'h7fef);
    chk(16'h1fff, {3'h0, cmdV});
    rc(16'h0032, 16'h0703, 1'b0);
    sequencerMode = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'h1fcf, {3'h0, cmdV});
    rc(16'h0032, 16'h0303, 1'b0);
    wr(16'h00ca, 16'hffc7);
    chk(16'h2ff9, {2'h0, cw2V});
    rc(16'h0034, 16'h0100, 1'b0);
    sequencerMode = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'h13ff, {2'h0, cw2V});
    wr(16'h00ca, 16'h0038);
    chk(16'h0000, {2'h0, cw2V});
    // link watchdog: traffic keeps it quiet, silence trips it
    wr(16'h00c9, 16'h0001);
    telGap = 8'h05;
    netTimeoutMode = 2'h2;
    repeat (60) @(negedge clk);
    chk(16'h0000, {15'h0000, linkFault_q});
    telGap = 8'h00;
    wt(1'b1, 0, 40);
    chk(16'h0001, {15'h0000, coastStop_q});
    chk(16'h002a, {8'h00, faultCode_q});
    wr(16'h00c9, 16'h8000);
    repeat (60) @(negedge clk);
    chk(16'h0000, {15'h0000, linkFault_q});
    netTimeoutMode = 2'h1;
    wt(1'b1, 1, 40);
    chk(16'h003a, {8'h00, faultCode_q});
    chk(16'h0000, {15'h0000, coastStop_q});
    rc(16'h0034, 16'h0008, 1'b0);
    telGap = 8'h05;
    wt(1'b0, 1, 10);
    telGap = 8'h00;
    netTimeoutMode = 2'h0;
    repeat (60) @(negedge clk);
    chk(16'h0000, {15'h0000, linkWarn_q});
    // keypad watchdog: 20 tenths at 4 cycles each
    kpdGap = 8'h06;
    keypadCtrlNeedsEnhanced = 1'b1;
    repeat (100) @(negedge clk);
    chk(16'h0000, {15'h0000, keypadFault_q});
    kpdGap = 8'h00;
    wt(1'b1, 2, 120);
    chk(16'h0028, {8'h00, faultCode_q});
    keypadRateLow = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'h5161, keypadBaudDiv_q);
    test_done;
  end
endmodule // tb_top
